// ===== ics_pkg.sv
// Constants and types for the interleaved core storage sequencer
// Overview of operation
// - 32,768 words of 48 bits, two units
// - Odd addresses one unit, even the other
// - Read delivers via exchange, then restores word
// - Write clears location, then stores source word
// - Full unit reference takes 6.4 microseconds
// - Read data available 2.2 microseconds after request
// - Odd and even cycles may overlap
// - Each unit writes from own restore register
// - Unit address register held whole cycle
// - Sensed pulse is one; reading zeroes cells
// - Inhibit bits staying zero during write
// - One plane per bit, planes share address
// - Unit decodes address to one location
// - Per-unit sequencer times every phase
// - Address bit 0 picks unit, 14 bits loaded
// - Address from operand, program or buffer counter
package ics_pkg;

    localparam int WORD_W = 48;
    localparam int ADDR_W = 15;
    localparam int UNIT_ADDR_W = 14;
    localparam int UNIT_WORDS = 16384;
    localparam int UNITS = 2;
    localparam int CNT_W = 6;

    // Timing figures in nanoseconds
    localparam int CLK_NS = 100;
    localparam int CYCLE_NS = 6400;
    localparam int ACCESS_NS = 2200;

    // Cycle counts derived from the clock rate
    localparam int CYCLE_CYC = CYCLE_NS / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

    // Sequencer step positions within one unit cycle
    localparam logic [CNT_W-1:0] SENSE_AT = 6'h00;
    localparam logic [CNT_W-1:0] CLEAR_AT = 6'h01;
    localparam logic [CNT_W-1:0] DELIVER_AT = CNT_W'(ACCESS_CYC - 1);
    localparam logic [CNT_W-1:0] RESTORE_AT = CNT_W'(CYCLE_CYC - 2);
    localparam logic [CNT_W-1:0] LAST_AT = CNT_W'(CYCLE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

    // Address source select codes
    localparam logic [1:0] SRC_OPERAND = 2'h0;
    localparam logic [1:0] SRC_PROGRAM = 2'h1;
    localparam logic [1:0] SRC_BUFFER = 2'h2;

    // Unit indices
    localparam int EVEN_UNIT = 0;
    localparam int ODD_UNIT = 1;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_READ,
        PH_WRITE
    } ics_phase_t;

    // One storage reference request
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] src;
        logic [1:0] dest;
    } ics_req_t;

    // Read answer towards the requester
    typedef struct packed {
        logic valid;
        logic [1:0] dest;
        logic [WORD_W-1:0] data;
    } ics_rsp_t;

    // Sequencer state of one unit
    typedef struct packed {
        ics_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic wr;
        logic [1:0] dest;
        logic [UNIT_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] restore;
    } ics_unit_t;

    // Whole state of the sequencer
    typedef struct packed {
        ics_unit_t [UNITS-1:0] unit;
        logic [WORD_W-1:0] xchg;
        logic rd_valid;
        logic [1:0] rd_dest;
    } ics_state_t;

endpackage

// ===== ics_core_store.sv
// Word store of one storage unit, one plane per word bit
`timescale 1ns/1ps
module ics_core_store
    import ics_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = UNIT_WORDS,
    parameter int AW = UNIT_ADDR_W
) (
    input wire logic clk_i, // Storage clock
    input wire logic rd_i, // Sense strobe
    input wire logic wr_i, // Write strobe
    input wire logic [AW-1:0] addr_i, // Location
    input wire logic [WIDTH-1:0] wdata_i, // Bits to set
    output logic [WIDTH-1:0] rdata_o // Sensed word
);
    logic [WIDTH-1:0] cells [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // All planes share one address; no reset, cores keep content
    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            cells[addr_i] <= wdata_i;
        end
        if (rd_i) begin
            rdata_q <= cells[addr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule // ics_core_store

// ===== ics_storage_sequencer.sv
// Sequencer for the two interleaved storage units
`timescale 1ns/1ps
module ics_storage_sequencer
    import ics_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = UNIT_WORDS
) (
    input wire logic mclk_i, // 10 MHz clock
    input wire logic resetn_i, // Async reset, low
    input wire ics_req_t req_i, // Reference request
    input wire logic [ADDR_W-1:0] operand_addr_i, // Operand address reg
    input wire logic [ADDR_W-1:0] program_addr_i, // Program address reg
    input wire logic [ADDR_W-1:0] buffer_addr_i, // Buffer addr counter
    input wire logic [WORD_W-1:0] wr_data_i, // Word to write
    output logic ready_o, // Request taken now
    output logic [UNITS-1:0] busy_o, // Unit busy, bit 1 odd
    output ics_rsp_t rsp_o, // Read answer
    output logic [UNIT_ADDR_W-1:0] even_addr_o, // Even address reg
    output logic [UNIT_ADDR_W-1:0] odd_addr_o // Odd address reg
);

    ics_state_t s_q;
    ics_state_t s_d;
    logic [ADDR_W-1:0] tgt;
    logic tgt_unit;
    logic hazard;
    logic accept;
    logic [UNITS-1:0] mem_rd;
    logic [UNITS-1:0] mem_wr;
    logic [UNITS-1:0][UNIT_ADDR_W-1:0] mem_addr;
    logic [UNITS-1:0][WORD_W-1:0] mem_wdata;
    logic [UNITS-1:0][WORD_W-1:0] mem_rdata;
    logic [UNITS-1:0][WORD_W-1:0] inhibit;

    // Pick the requester's address register
    function automatic logic [ADDR_W-1:0] sel_addr(
        input logic [1:0] src,
        input logic [ADDR_W-1:0] opnd,
        input logic [ADDR_W-1:0] prog,
        input logic [ADDR_W-1:0] buf_a
    );
        logic [ADDR_W-1:0] a;
        a = buf_a;
        if (src == SRC_OPERAND) begin
            a = opnd;
        end else if (src == SRC_PROGRAM) begin
            a = prog;
        end
        return a;
    endfunction

    // True while this unit is about to drive the exchange register
    function automatic logic delivers(input ics_unit_t u);
        return (u.phase == PH_READ) && !u.wr && (u.cnt == DELIVER_AT);
    endfunction

    // Address source and unit choice from the low address bit
    assign tgt = sel_addr(req_i.src, operand_addr_i, program_addr_i,
        buffer_addr_i);
    assign tgt_unit = tgt[0];

    // Writes pass through the exchange register; refuse a write
    // in the cycle a read answer loads it, else one word is lost
    assign hazard = req_i.write &&
        (delivers(s_q.unit[EVEN_UNIT]) || delivers(s_q.unit[ODD_UNIT]));

    // Busy unit refuses new work until its cycle ends
    always_comb begin
        for (int u = 0; u < UNITS; u++) begin
            busy_o[u] = (s_q.unit[u].phase != PH_IDLE);
        end
    end

    assign accept = req_i.valid && !busy_o[tgt_unit] && !hazard;
    assign ready_o = accept;

    // Next state for both units and the shared exchange register
    always_comb begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        mem_rd = '0;
        mem_wr = '0;
        mem_wdata = '0;
        inhibit = '0;
        for (int u = 0; u < UNITS; u++) begin
            mem_addr[u] = s_q.unit[u].addr;
            unique case (s_q.unit[u].phase)
                PH_IDLE: begin
                    if (accept && (tgt_unit == u[0])) begin
                        s_d.unit[u].phase = PH_READ;
                        s_d.unit[u].cnt = '0;
                        s_d.unit[u].wr = req_i.write;
                        s_d.unit[u].dest = req_i.dest;
                        // Upper 14 bits held for the whole cycle
                        s_d.unit[u].addr = tgt[ADDR_W-1:1];
                        if (req_i.write) begin
                            s_d.xchg = wr_data_i;
                        end
                    end
                end
                PH_READ: begin
                    s_d.unit[u].cnt = s_q.unit[u].cnt + CNT_ONE;
                    if (s_q.unit[u].cnt == SENSE_AT) begin
                        mem_rd[u] = 1'b1;
                        if (s_q.unit[u].wr) begin
                            // Write word moves on before xchg is reused
                            s_d.unit[u].restore = s_q.xchg;
                        end
                    end
                    if (s_q.unit[u].cnt == CLEAR_AT) begin
                        // Read drive leaves every cell at zero
                        mem_wr[u] = 1'b1;
                        if (!s_q.unit[u].wr) begin
                            // Sensed pulse is a one, none a zero
                            s_d.unit[u].restore = mem_rdata[u];
                        end
                    end
                    if (delivers(s_q.unit[u])) begin
                        s_d.xchg = s_q.unit[u].restore;
                        s_d.rd_valid = 1'b1;
                        s_d.rd_dest = s_q.unit[u].dest;
                    end
                    if (s_q.unit[u].cnt == RESTORE_AT - CNT_ONE) begin
                        s_d.unit[u].phase = PH_WRITE;
                    end
                end
                PH_WRITE: begin
                    s_d.unit[u].cnt = s_q.unit[u].cnt + CNT_ONE;
                    if (s_q.unit[u].cnt == RESTORE_AT) begin
                        // Inhibit every bit that must stay zero
                        inhibit[u] = ~s_q.unit[u].restore;
                        mem_wr[u] = 1'b1;
                        mem_wdata[u] = ~inhibit[u];
                    end
                    if (s_q.unit[u].cnt == LAST_AT) begin
                        s_d.unit[u].phase = PH_IDLE;
                        s_d.unit[u].cnt = '0;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Two identical, independent units: bit 0 even, bit 1 odd
    for (genvar g = 0; g < UNITS; g++) begin : g_unit
        ics_core_store #(
            .WIDTH(WIDTH),
            .DEPTH(DEPTH),
            .AW(UNIT_ADDR_W)
        ) u_store (
            .clk_i(mclk_i),
            .rd_i(mem_rd[g]),
            .wr_i(mem_wr[g]),
            .addr_i(mem_addr[g]),
            .wdata_i(mem_wdata[g]),
            .rdata_o(mem_rdata[g])
        );
    end

    // Answer straight from the exchange register flops
    assign rsp_o.valid = s_q.rd_valid;
    assign rsp_o.dest = s_q.rd_dest;
    assign rsp_o.data = s_q.xchg;
    assign even_addr_o = s_q.unit[EVEN_UNIT].addr;
    assign odd_addr_o = s_q.unit[ODD_UNIT].addr;

endmodule // ics_storage_sequencer

// ===== ics_seq_assertions.sv
// Port checker for the storage sequencer
`timescale 1ns/1ps
module ics_seq_assertions
    import ics_pkg::*;
(
    input wire logic mclk_i, // Clock
    input wire logic resetn_i, // Reset, low
    input wire ics_req_t req_i, // Request
    input wire logic [ADDR_W-1:0] operand_addr_i, // Operand addr
    input wire logic [ADDR_W-1:0] program_addr_i, // Program addr
    input wire logic [ADDR_W-1:0] buffer_addr_i, // Buffer addr
    input wire logic [WORD_W-1:0] wr_data_i, // Write word
    input wire logic ready_o, // Taken
    input wire logic [UNITS-1:0] busy_o, // Busy
    input wire ics_rsp_t rsp_o, // Answer
    input wire logic [UNIT_ADDR_W-1:0] even_addr_o, // Even addr
    input wire logic [UNIT_ADDR_W-1:0] odd_addr_o // Odd addr
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    logic [ADDR_W-1:0] sel;
    logic [UNIT_ADDR_W-1:0] sel_hi;
    logic rd_acc;
    logic [6:0] cnt_q;
    // Address the request points at; code 3 counts as buffer
    assign sel = req_i.src == SRC_OPERAND ? operand_addr_i :
        req_i.src == SRC_PROGRAM ? program_addr_i : buffer_addr_i;
    assign sel_hi = sel[ADDR_W-1:1];
    assign rd_acc = ready_o && !req_i.write;
    // Busy run length of the even unit, too long for a repetition
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i)
            cnt_q <= 7'h00;
        else
            cnt_q <= busy_o[0] ? cnt_q + 7'h01 : 7'h00;
    end
    property p_no_busy_take; ready_o |-> !busy_o[sel[0]]; endproperty
    a_no_busy_take: assert property (p_no_busy_take)
        else $error("request taken by busy unit");
    property p_even_go;
        ready_o && !sel[0] |=> busy_o[0] && even_addr_o == $past(sel_hi);
    endproperty
    a_even_go: assert property (p_even_go)
        else $error("even unit not started");
    property p_odd_go;
        ready_o && sel[0] |=> busy_o[1] && odd_addr_o == $past(sel_hi);
    endproperty
    a_odd_go: assert property (p_odd_go)
        else $error("odd unit not started");
    property p_busy_len; $fell(busy_o[0]) |-> cnt_q == 7'h40; endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("unit cycle length wrong");
    property p_busy_cause; $rose(busy_o[1]) |-> $past(ready_o); endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without request");
    property p_addr_hold;
        $rose(busy_o[1]) |-> ##1 $stable(odd_addr_o) [*8];
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved in cycle");
    property p_rd_lat;
        rd_acc |-> ##23 rsp_o.valid && rsp_o.dest == $past(req_i.dest, 23);
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late or mistagged");
    property p_rd_cause; rsp_o.valid |-> $past(rd_acc, 23); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("answer without read");
    property p_wr_xchg;
        ready_o && req_i.write |=> rsp_o.data == $past(wr_data_i);
    endproperty
    a_wr_xchg: assert property (p_wr_xchg)
        else $error("exchange not loaded on write");
    c_read: cover property (rd_acc);
    c_write: cover property (ready_o && req_i.write);
    c_overlap: cover property (busy_o == 2'b11);
    c_hazard: cover property (req_i.valid && req_i.write && !ready_o &&
        !busy_o[sel[0]]);
endmodule // ics_seq_assertions

bind ics_storage_sequencer ics_seq_assertions chk_u (.mclk_i, .resetn_i,
    .req_i, .operand_addr_i, .program_addr_i, .buffer_addr_i, .wr_data_i,
    .ready_o, .busy_o, .rsp_o, .even_addr_o, .odd_addr_o);

// ===== ics_req_model.sv
// Requester model for the processor sections
`timescale 1ns/1ps
module ics_req_model
    import ics_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic ready_i, // Taken
    output ics_req_t req_o, // Request
    output logic [ADDR_W-1:0] opnd_o, // Operand addr
    output logic [ADDR_W-1:0] prog_o, // Program addr
    output logic [ADDR_W-1:0] buf_o, // Buffer addr
    output logic [WORD_W-1:0] data_o // Write word
);
    initial begin
        req_o = '0;
        opnd_o = '0;
        prog_o = '0;
        buf_o = '0;
        data_o = '0;
    end
    // Unused sources carry the inverse, so a wrong pick shows
    task automatic xfer(input logic wr, input logic [1:0] src, dst,
        input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
        output int wt);
        wt = 0;
        @(negedge clk_i);
        req_o = '{1'b1, wr, src, dst};
        opnd_o = src == SRC_OPERAND ? a : ~a;
        prog_o = src == SRC_PROGRAM ? a : ~a;
        buf_o = src[1] ? a : ~a;
        data_o = d;
        #10;
        // Hold until taken or 200 retries pass, never start on a busy unit
        while (ready_i !== 1'b1 && wt < 200) begin
            @(negedge clk_i);
            #10;
            wt++;
        end
        @(negedge clk_i);
        req_o.valid = 1'b0;
        opnd_o = ~opnd_o;
        prog_o = ~prog_o;
        buf_o = ~buf_o;
        data_o = ~d;
    endtask
endmodule // ics_req_model

// ===== testbench.sv
// Self-checking bench for the storage sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    bad_count++; $display("Error %s expected %h seen %h", nm, exp, got); \
    end end
module testbench
    import ics_pkg::*;
;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    ics_req_t req;
    logic [ADDR_W-1:0] opnd, prog, bufa;
    logic [WORD_W-1:0] wdat;
    logic ready;
    logic [UNITS-1:0] busy;
    ics_rsp_t rsp;
    logic [UNIT_ADDR_W-1:0] even_a, odd_a;
    int bad_count = 0;
    int compares = 0;
    int wt;
    localparam logic [WORD_W-1:0] D1 = 48'h5a5a_0f0f_c3c3;
    localparam logic [WORD_W-1:0] D2 = 48'h8001_2480_7ffe;
    always #50 mclk_i = ~mclk_i;
    ics_storage_sequencer dut_u (.mclk_i, .resetn_i, .req_i(req),
        .operand_addr_i(opnd), .program_addr_i(prog), .buffer_addr_i(bufa),
        .wr_data_i(wdat), .ready_o(ready), .busy_o(busy), .rsp_o(rsp),
        .even_addr_o(even_a), .odd_addr_o(odd_a));
    ics_req_model req_u (.clk_i(mclk_i), .ready_i(ready), .req_o(req),
        .opnd_o(opnd), .prog_o(prog), .buf_o(bufa), .data_o(wdat));
    // Read one word and judge tag, data and access time
    task automatic rd(input logic [1:0] src, dst, input logic [14:0] a,
        input logic [WORD_W-1:0] exp);
        req_u.xfer(1'b0, src, dst, a, '0, wt);
        repeat (ACCESS_CYC - 1) @(negedge mclk_i);
        `CHK("early valid", 1'b0, rsp.valid)
        @(negedge mclk_i);
        `CHK("valid", 1'b1, rsp.valid)
        `CHK("dest", dst, rsp.dest)
        `CHK("data", exp, rsp.data)
    endtask
    // Write then read back; the read is refused until the unit is free
    task automatic t_write_read();
        req_u.xfer(1'b1, SRC_OPERAND, 2'h0, 15'h0010, D1, wt);
        `CHK("even addr", 14'h0008, even_a)
        `CHK("even busy", 2'b01, busy)
        rd(SRC_PROGRAM, 2'h2, 15'h0010, D1);
        `CHK("refused", 1'b1, wt >= CYCLE_CYC - 1)
    endtask
    // Odd and even reads back to back; even word was restored
    task automatic t_overlap();
        req_u.xfer(1'b1, SRC_BUFFER, 2'h0, 15'h0011, D2, wt);
        `CHK("odd addr", 14'h0008, odd_a)
        repeat (CYCLE_CYC) @(negedge mclk_i);
        req_u.xfer(1'b0, SRC_OPERAND, 2'h1, 15'h0010, '0, wt);
        req_u.xfer(1'b0, SRC_PROGRAM, 2'h3, 15'h0011, '0, wt);
        `CHK("overlap wait", 0, wt)
        `CHK("both busy", 2'b11, busy)
        repeat (ACCESS_CYC - 1) @(negedge mclk_i);
        `CHK("even data", D1, rsp.data)
        `CHK("even dest", 2'h1, rsp.dest)
        @(negedge mclk_i);
        `CHK("odd data", D2, rsp.data)
        `CHK("odd dest", 2'h3, rsp.dest)
    endtask
    // Overwrite ones with zeros, and use the top address
    task automatic t_clear();
        req_u.xfer(1'b1, SRC_PROGRAM, 2'h0, 15'h0010, 48'h0000_ffff_0000, wt);
        rd(2'h3, 2'h0, 15'h0010, 48'h0000_ffff_0000);
        req_u.xfer(1'b1, SRC_OPERAND, 2'h0, 15'h7fff, '1, wt);
        `CHK("top addr", 14'h3fff, odd_a)
        rd(SRC_OPERAND, 2'h1, 15'h7fff, '1);
    endtask
    // Write meets a read delivery: held one cycle, word kept
    task automatic t_hazard();
        req_u.xfer(1'b0, SRC_OPERAND, 2'h2, 15'h7fff, '0, wt);
        repeat (ACCESS_CYC - 2) @(negedge mclk_i);
        req_u.xfer(1'b1, SRC_PROGRAM, 2'h0, 15'h0010, D2, wt);
        `CHK("hazard wait", 1, wt)
        `CHK("hazard dest", 2'h2, rsp.dest)
        `CHK("write word", D2, rsp.data)
        rd(SRC_OPERAND, 2'h1, 15'h0010, D2);
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(negedge mclk_i);
        resetn_i = 1'b1;
        t_write_read();
        t_overlap();
        t_clear();
        t_hazard();
        print_verdict();
    end
    // Watchdog, about five times the expected run
    initial begin
        #(3000 * CLK_NS);
        bad_count++;
        print_verdict();
    end
endmodule // testbench
